// [src/dma_chan_pkg.sv]
// constants, field layout and carrier types of the dma channel control block
// assumes a 32-bit avalon-mm slave port with byte addresses
package dma_chan_pkg;

  // ----------------------------------------------------------------
  // register byte offsets (word aligned)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_LEVEL_VECTOR = 12'h784;
  localparam logic [11:0] OFF_CONTROL      = 12'h788;
  localparam logic [11:0] OFF_STATUS       = 12'h78c;
  localparam logic [11:0] OFF_SRC_PTR      = 12'h790;
  localparam logic [11:0] OFF_DST_PTR      = 12'h794;

  // ----------------------------------------------------------------
  // channel control field positions
  // ----------------------------------------------------------------
  localparam int CCR_BRK_IE   = 15;
  localparam int CCR_NRM_IE   = 14;
  localparam int CCR_ERR_IE   = 13;
  localparam int CCR_ECO      = 12;
  localparam int CCR_SRC_INC  = 11;
  localparam int CCR_DST_INC  = 10;
  localparam int CCR_SOURCE_OPERAND_SIZE    = 8;   // two bits, 9:8
  localparam int CCR_DEST_OPERAND_SIZE    = 6;   // two bits, 7:6
  localparam int CCR_REQ      = 4;   // two bits, 5:4
  localparam int CCR_BB       = 2;   // two bits, 3:2
  localparam int CCR_SINGLE   = 1;
  localparam int CCR_START    = 0;

  // status layout: summary at 7, termination bits at 6:2
  localparam int ST_SUMMARY   = 7;
  localparam int ST_LSB       = 2;   // five bits, 6:2
  localparam int TS_DONE      = 4;   // positions inside the 5-bit group
  localparam int TS_SRC_ERR   = 3;
  localparam int TS_DST_ERR   = 2;
  localparam int TS_SETUP_CONFIG_ERROR      = 1;
  localparam int TS_BREAKPOINT_STATUS      = 0;

  // level/vector layout
  localparam int IV_LEVEL     = 8;   // three bits, 10:8

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0]  VECTOR_RST  = 8'h0f;
  localparam logic [2:0]  LEVEL_RST   = 3'h0;
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [31:0] PTR_RST     = 32'h0000_0000;

  localparam logic [1:0] SZ_LONG   = 2'h0;
  localparam logic [1:0] SZ_BYTE   = 2'h1;
  localparam logic [1:0] SZ_WORD   = 2'h2;
  localparam logic [1:0] SZ_UNUSED = 2'h3;

  localparam logic [1:0] RQ_INTERNAL = 2'h0;
  localparam logic [1:0] RQ_RESERVED = 2'h1;
  localparam logic [1:0] RQ_BURST    = 2'h2;
  localparam logic [1:0] RQ_STEAL    = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // bandwidth window: 1024 clocks, shares in slices of 256 clocks
  localparam int BW_WINDOW_CLK = 1024;
  localparam int BW_SLICE_CLK  = 256;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        read;
    logic        write;
    logic [11:0] address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } av_req_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  size;
    logic [31:0] address;
  } cyc_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } eng_state_t;

endpackage

// [src/dma_channel_control_and_interrupt.sv]
// control, status and interrupt logic of one dma channel with a small
// operand sequencer; registers reached over avalon-mm with waitrequest
// assumes the bus-cycle unit outside runs each cycle it is handed and
// answers with cycle_ack or cycle_bus_error; all inputs but rstn are synchronous
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/10ps

// Behaviour
// - level/vector register: supervisor only, not stopped
// - pending interrupt drives programmed level out
// - 8-bit vector, resets to 0f
// - control register: any privilege, not stopped
// - breakpoint enable and breakpoint status raise interrupt
// - normal enable and done status raise interrupt
// - error enable with any error raises interrupt
// - external option ignored in internal request mode
// - single mode: option picks read/write handshake portion
// - dual mode: option picks requesting portion
// - source pointer steps 1/2/4 when enabled
// - destination pointer steps 1/2/4 when enabled
// - source cycle size from control 9:8
// - destination cycle size from control 7:6
// - request mode from control 5:4
// - internal mode bus share per 1024 clocks
// - single mode one cycle, else dual cycles
// - start clears on reset, zero write, termination
// - start refused while any termination status set
// - internal mode runs while start set
// - external mode waits for request input
// - control writes act at once; halt after cycle (in dual mode the write cycle still follows the read)
// - summary bit is or of termination bits
// - termination bits clear on write one
module dma_channel_control_and_interrupt
  import dma_chan_pkg::*;
(
  input  wire logic    mclk,                     // module clock, 40 mhz
  input  wire logic    rstn,                     // async reset, low
  input  wire av_req_t avs_req,                  // avalon request group
  output logic [31:0]  avs_readdata,             // avalon read data
  output logic         avs_waitrequest,          // avalon stall
  output logic [1:0]   avs_response,             // okay or slave error
  input  wire logic    supervisor,               // access privilege
  input  wire logic    module_stop_control,      // module stopped
  input  wire logic    transfer_request_in,      // peripheral request
  output logic         transfer_acknowledge_out, // handshake ack, high
  output cyc_t         cycle_out,                // bus cycle order
  input  wire logic    cycle_ack,                // bus cycle finished
  input  wire logic    cycle_bus_error,          // bus cycle failed
  input  wire logic    last_operand,             // count reaches end
  input  wire logic    breakpoint_in,            // breakpoint seen
  output logic         irq_request,              // interrupt request
  output logic [2:0]   irq_priority_level        // level on irq lines
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  be);
    logic [15:0] r;
    r = old_v;
    if (be[0]) r[7:0] = new_v[7:0];
    if (be[1]) r[15:8] = new_v[15:8];
    return r;
  endfunction

  function automatic logic [31:0] merge32(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction

  // step after one operand: byte 1, word 2, long 4
  function automatic logic [31:0] size_step(input logic [1:0] sz);
    logic [31:0] r;
    r = 32'h0000_0004;
    if (sz == SZ_BYTE) r = 32'h0000_0001;
    else if (sz == SZ_WORD) r = 32'h0000_0002;
    return r;
  endfunction

  // unused size code or misaligned word/long address
  function automatic logic size_bad(input logic [1:0] sz,
                                    input logic       a0);
    return (sz == SZ_UNUSED) || ((sz != SZ_BYTE) && a0);
  endfunction

  // clocks allowed per window: 256 * (code + 1)
  function automatic logic [10:0] bw_limit(input logic [1:0] bb);
    logic [10:0] r;
    r = 11'((32'(bb) + 32'h1) * BW_SLICE_CLK);
    return r;
  endfunction

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;

  // two flops so release never lands near a clock edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [2:0]  level_q;
  logic [7:0]  vector_q;
  logic [15:0] control_q;    // bit 0 unused here, start lives in start_q
  logic        start_q;
  logic [4:0]  term_q;       // done, src err, dst err, setup_config_error, breakpoint_status
  logic [31:0] src_ptr_q;
  logic [31:0] dst_ptr_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [1:0]  resp_q;

  // ----------------------------------------------------------------
  // avalon slave decode
  // ----------------------------------------------------------------
  logic        bus_req;
  logic        acc_ok;
  logic [31:0] rd_word;
  logic [2:0]  sel;          // 0 lv,1 ctl,2 status,3 src,4 dst,7 none
  logic        wr_go;
  logic [15:0] wd16;

  assign bus_req = avs_req.read | avs_req.write;
  assign wd16    = avs_req.writedata[15:0];

  // privilege and stop checks per register
  always_comb begin
    sel     = 3'h7;
    rd_word = 32'h0000_0000;
    acc_ok  = 1'b0;
    case (avs_req.address[11:2])
      OFF_LEVEL_VECTOR[11:2]: begin
        sel     = 3'h0;
        rd_word = {21'h0, level_q, vector_q};
        acc_ok  = supervisor & ~module_stop_control;
      end
      OFF_CONTROL[11:2]: begin
        sel     = 3'h1;
        rd_word = {16'h0, control_q[15:1], start_q};
        acc_ok  = ~module_stop_control;
      end
      OFF_STATUS[11:2]: begin
        sel     = 3'h2;
        rd_word = {24'h0, |term_q, term_q, 2'h0};
        acc_ok  = ~module_stop_control;
      end
      OFF_SRC_PTR[11:2]: begin
        sel     = 3'h3;
        rd_word = src_ptr_q;
        acc_ok  = ~module_stop_control;
      end
      OFF_DST_PTR[11:2]: begin
        sel     = 3'h4;
        rd_word = dst_ptr_q;
        acc_ok  = ~module_stop_control;
      end
      default: begin
        sel     = 3'h7;
        rd_word = 32'h0000_0000;
        acc_ok  = 1'b0;
      end
    endcase
  end

  // writes land on the edge where waitrequest is seen low
  assign wr_go = avs_req.write & ~wait_q & acc_ok;

  // one stall cycle per access; answer registered for clean timing
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
      resp_q  <= RESP_OKAY;
    end else if (wait_q && bus_req) begin
      wait_q  <= 1'b0;
      rdata_q <= (avs_req.read && acc_ok) ? rd_word : 32'h0000_0000;
      resp_q  <= acc_ok ? RESP_OKAY : RESP_SLVERR;
    end else begin
      wait_q  <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // level and vector
  // ----------------------------------------------------------------
  logic [15:0] lv_new;
  assign lv_new = merge16({5'h0, level_q, vector_q}, wd16,
                          avs_req.byteenable[1:0]);

  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      level_q  <= LEVEL_RST;
      vector_q <= VECTOR_RST;
    end else if (wr_go && sel == 3'h0) begin
      level_q  <= lv_new[IV_LEVEL +: 3];
      vector_q <= lv_new[7:0];
    end
  end

  // ----------------------------------------------------------------
  // channel control fields
  // ----------------------------------------------------------------
  logic [1:0] source_operand_size;
  logic [1:0] dest_operand_size;
  logic [1:0] req_mode;
  logic       ext_mode;
  logic       eco_eff;
  logic       single;

  // fields act at once, even mid-transfer
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      control_q <= CONTROL_RST;
    end else if (wr_go && sel == 3'h1) begin
      control_q <= merge16(control_q, wd16,
                           avs_req.byteenable[1:0]);
    end
  end

  assign source_operand_size    = control_q[CCR_SOURCE_OPERAND_SIZE +: 2];
  assign dest_operand_size    = control_q[CCR_DEST_OPERAND_SIZE +: 2];
  assign req_mode = control_q[CCR_REQ +: 2];
  assign ext_mode = req_mode[1];
  assign eco_eff  = control_q[CCR_ECO] & ext_mode;
  assign single   = control_q[CCR_SINGLE];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  eng_state_t state_q;
  logic [4:0] term_ev;
  logic       run;
  logic       grant;
  logic       launch;
  logic       setup_config_error_bad;
  logic       steal_arm_q;
  logic [9:0] win_q;
  logic [10:0] used_q;

  // running needs start set and all termination bits clear
  assign run = start_q & ~(|term_q) & ~module_stop_control;

  // request source by mode; reserved code never starts
  always_comb begin
    case (req_mode)
      RQ_INTERNAL: grant = used_q <
                           bw_limit(control_q[CCR_BB +: 2]);
      RQ_BURST:    grant = transfer_request_in;
      RQ_STEAL:    grant = transfer_request_in & steal_arm_q;
      default:     grant = 1'b0;
    endcase
  end

  assign launch   = run & grant & (state_q == ST_IDLE);
  assign setup_config_error_bad = size_bad(source_operand_size, src_ptr_q[0]) |
                    size_bad(dest_operand_size, dst_ptr_q[0]);

  // termination events raised by the sequencer this cycle
  always_comb begin
    term_ev = 5'h00;
    if (launch && setup_config_error_bad) term_ev[TS_SETUP_CONFIG_ERROR] = 1'b1;
    if (state_q != ST_IDLE && breakpoint_in) term_ev[TS_BREAKPOINT_STATUS] = 1'b1;
    if (state_q == ST_READ && cycle_bus_error) term_ev[TS_SRC_ERR] = 1'b1;
    if (state_q == ST_WRITE && cycle_bus_error) term_ev[TS_DST_ERR] = 1'b1;
    if (cycle_ack && !cycle_bus_error && last_operand &&
        (state_q == ST_WRITE || (state_q == ST_READ && single)))
      term_ev[TS_DONE] = 1'b1;
  end

  // bandwidth window: count clocks spent busy in each 1024 clocks
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      win_q  <= 10'h000;
      used_q <= 11'h000;
    end else begin
      win_q <= win_q + 10'h001;
      if (32'(win_q) == BW_WINDOW_CLK - 1)
        used_q <= 11'h000;
      else if (state_q != ST_IDLE)
        used_q <= used_q + 11'h001;
    end
  end

  // cycle steal takes one operand per request; rearm once it drops
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      steal_arm_q <= 1'b1;
    end else if (launch && req_mode == RQ_STEAL) begin
      steal_arm_q <= 1'b0;
    end else if (!transfer_request_in) begin
      steal_arm_q <= 1'b1;
    end
  end

  // operand sequencing; a cleared start halts only after the operand, a dual read still goes on to its write
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q                  <= ST_IDLE;
      cycle_out                <= '0;
      transfer_acknowledge_out <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (launch && !setup_config_error_bad) begin
            if (single && !eco_eff && ext_mode) begin
              // requester supplies data: write to memory
              state_q   <= ST_WRITE;
              cycle_out <= '{1'b1, 1'b1, dest_operand_size, dst_ptr_q};
              transfer_acknowledge_out <= 1'b1;
            end else begin
              state_q   <= ST_READ;
              cycle_out <= '{1'b1, 1'b0, source_operand_size, src_ptr_q};
              transfer_acknowledge_out <= ext_mode &
                                          (single | eco_eff);
            end
          end
        end
        ST_READ: begin
          if (cycle_bus_error || (cycle_ack && single)) begin
            state_q                  <= ST_IDLE;
            cycle_out                <= '0;
            transfer_acknowledge_out <= 1'b0;
          end else if (cycle_ack) begin
            state_q   <= ST_WRITE;
            cycle_out <= '{1'b1, 1'b1, dest_operand_size, dst_ptr_q};
            transfer_acknowledge_out <= ext_mode & ~eco_eff;
          end
        end
        ST_WRITE: begin
          if (cycle_bus_error || cycle_ack) begin
            state_q                  <= ST_IDLE;
            cycle_out                <= '0;
            transfer_acknowledge_out <= 1'b0;
          end
        end
        default: begin
          state_q                  <= ST_IDLE;
          cycle_out                <= '0;
          transfer_acknowledge_out <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // address pointers
  // ----------------------------------------------------------------
  // a software write in the same cycle as a step wins
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      src_ptr_q <= PTR_RST;
    end else if (wr_go && sel == 3'h3) begin
      src_ptr_q <= merge32(src_ptr_q, avs_req.writedata,
                           avs_req.byteenable);
    end else if (state_q == ST_READ && cycle_ack && !cycle_bus_error &&
                 control_q[CCR_SRC_INC]) begin
      src_ptr_q <= src_ptr_q + size_step(source_operand_size);
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      dst_ptr_q <= PTR_RST;
    end else if (wr_go && sel == 3'h4) begin
      dst_ptr_q <= merge32(dst_ptr_q, avs_req.writedata,
                           avs_req.byteenable);
    end else if (state_q == ST_WRITE && cycle_ack && !cycle_bus_error &&
                 control_q[CCR_DST_INC]) begin
      dst_ptr_q <= dst_ptr_q + size_step(dest_operand_size);
    end
  end

  // ----------------------------------------------------------------
  // status and start
  // ----------------------------------------------------------------
  logic [4:0] term_clr;
  assign term_clr = (wr_go && sel == 3'h2 && avs_req.byteenable[0]) ?
                    avs_req.writedata[ST_LSB +: 5] : 5'h00;

  // new events beat a simultaneous write-one clear
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      term_q <= 5'h00;
    end else begin
      term_q <= (term_q & ~term_clr) | term_ev;
    end
  end

  // start may not be set over a pending termination
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      start_q <= 1'b0;
    end else if (|term_ev) begin
      start_q <= 1'b0;
    end else if (wr_go && sel == 3'h1 && avs_req.byteenable[0]) begin
      start_q <= wd16[CCR_START] & ~(|term_q);
    end
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  logic irq_pend;
  assign irq_pend =
    (control_q[CCR_BRK_IE] & term_q[TS_BREAKPOINT_STATUS]) |
    (control_q[CCR_NRM_IE] & term_q[TS_DONE]) |
    (control_q[CCR_ERR_IE] & (term_q[TS_SRC_ERR] |
                              term_q[TS_DST_ERR] |
                              term_q[TS_SETUP_CONFIG_ERROR]));

  // held while pending, gone once software clears the bits
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      irq_request        <= 1'b0;
      irq_priority_level <= 3'h0;
    end else begin
      irq_request        <= irq_pend;
      irq_priority_level <= irq_pend ? level_q : 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // bus outputs
  // ----------------------------------------------------------------
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign avs_response    = resp_q;

endmodule

// [tb/dma_chan_properties.sv]
// timing checker for the dma channel control block
// assumes it sees the top module ports only, attached by bind
`timescale 1ns/10ps
module dma_chan_properties
  import dma_chan_pkg::*;
(
  input wire logic        mclk,                     // clock
  input wire logic        rstn,                     // reset, low
  input wire av_req_t     avs_req,                  // bus request
  input wire logic        avs_waitrequest,          // bus stall
  input wire logic [1:0]  avs_response,             // bus answer
  input wire logic        supervisor,               // privilege
  input wire logic        module_stop_control,      // stopped
  input wire logic        transfer_acknowledge_out, // handshake
  input wire cyc_t        cycle_out,                // cycle order
  input wire logic        cycle_ack,                // cycle ok
  input wire logic        cycle_bus_error,          // cycle failed
  input wire logic        irq_request,              // interrupt
  input wire logic [2:0]  irq_priority_level        // irq level
);
  // ------
  // access steps and properties
  // ------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic req;
  assign req = avs_req.read | avs_req.write;
  sequence s_taken; req && avs_waitrequest; endsequence
  sequence s_answer; !avs_waitrequest ##1 avs_waitrequest; endsequence
  a_wait_one_stall: assert property (
    s_taken |=> s_answer) else $error("access not answered in one stall");
  a_stop_refused: assert property (
    (s_taken and module_stop_control) |=> avs_response == RESP_SLVERR)
    else $error("access while stopped not refused");
  a_vector_priv: assert property (
    (s_taken and (!supervisor && avs_req.address[11:2] ==
    OFF_LEVEL_VECTOR[11:2])) |=> avs_response == RESP_SLVERR)
    else $error("user access to level and vector accepted");
  a_cycle_held: assert property (
    cycle_out.valid && !cycle_ack && !cycle_bus_error |=>
    $stable(cycle_out)) else $error("cycle order changed before answer");
  a_error_ends: assert property (
    cycle_bus_error && cycle_out.valid |=> !cycle_out.valid)
    else $error("cycle launched after bus error");
  a_ack_in_cycle: assert property (
    transfer_acknowledge_out |-> cycle_out.valid)
    else $error("handshake outside a cycle");
  a_level_idle: assert property (
    !irq_request |-> irq_priority_level == 3'h0)
    else $error("level shown without request");
  a_size_legal: assert property (
    cycle_out.valid |-> cycle_out.size != SZ_UNUSED &&
    !(cycle_out.size != SZ_BYTE && cycle_out.address[0]))
    else $error("cycle with unused size or odd address");
endmodule

bind dma_channel_control_and_interrupt dma_chan_properties u_props (.*);

// [tb/dma_mem_model.sv]
// memory and bus-cycle unit seen from the channel's cycle order port
// assumes the bench picks wait states and forces bus errors
`timescale 1ns/10ps
module dma_mem_model
  import dma_chan_pkg::*;
(
  input  wire logic       mclk,            // clock
  input  wire cyc_t       cycle_out,       // ordered cycle
  input  wire logic [1:0] slow,            // wait states
  input  wire logic       err,             // fail cycles
  output logic            cycle_ack,       // cycle ok, pulse
  output logic            cycle_bus_error  // cycle failed, pulse
);
  // ------
  // cycle answer
  // ------
  logic [1:0] wait_q;
  logic       go;
  // one answer per order; never answers twice in a row
  assign go = cycle_out.valid && !cycle_ack && !cycle_bus_error &&
              wait_q == slow;
  initial begin
    cycle_ack = 1'b0;
    cycle_bus_error = 1'b0;
    wait_q = 2'h0;
  end
  always @(posedge mclk) begin
    cycle_ack <= go && !err;
    cycle_bus_error <= go && err;
    wait_q <= (go || !cycle_out.valid || cycle_ack) ? 2'h0 : wait_q + 2'h1;
  end
endmodule

// [tb/test_dma_channel_control_and_interrupt.sv]
// self-checking bench of the dma channel control block
// assumes the memory model answers every ordered bus cycle
`timescale 1ns/10ps
module test_dma_channel_control_and_interrupt
  import dma_chan_pkg::*;
;
  logic        mclk, rstn, supervisor, module_stop_control, err;
  logic        transfer_request_in, last_operand, breakpoint_in;
  logic        avs_waitrequest, transfer_acknowledge_out, irq_request;
  logic        cycle_ack, cycle_bus_error;
  logic [1:0]  slow, avs_response;
  logic [2:0]  irq_priority_level;
  logic [31:0] avs_readdata;
  av_req_t     avs_req;
  cyc_t        cycle_out;
  int          error_cnt, samples_checked;

  dma_channel_control_and_interrupt dut (.*);
  dma_mem_model mem (.*);

  // ------
  // clock and shared tasks
  // ------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // d is write data, or expected read data on a read
  task automatic acc(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [1:0] rsp);
    avs_req <= '{~wr, wr, a, d, 4'hf};
    // no cycle limit here: a hang is left to the watchdog
    do begin
      @(posedge mclk);
    end while (avs_waitrequest);
    chk(40'(avs_response), 40'(rsp));
    if (!wr) chk(40'(avs_readdata), 40'(d));
    avs_req <= '0;
    @(posedge mclk);
  endtask

  task automatic cyc(input logic w, input logic [31:0] a,
                     input logic [1:0] s);
    repeat (40) if (!(cycle_out.valid && cycle_out.write == w))
      @(posedge mclk);
    chk(40'(cycle_out), 40'({1'b1, w, s, a}));
  endtask

  task automatic t_regs;
    acc(1'b0, OFF_LEVEL_VECTOR, 32'hf, RESP_OKAY);
    acc(1'b0, OFF_CONTROL, 32'h0, RESP_OKAY);
    supervisor <= 1'b0;
    acc(1'b1, OFF_LEVEL_VECTOR, 32'h540, RESP_SLVERR);
    acc(1'b0, OFF_CONTROL, 32'h0, RESP_OKAY);
    supervisor <= 1'b1;
    acc(1'b1, OFF_LEVEL_VECTOR, 32'h540, RESP_OKAY);
    acc(1'b0, OFF_LEVEL_VECTOR, 32'h540, RESP_OKAY);
    module_stop_control <= 1'b1;
    acc(1'b0, OFF_CONTROL, 32'h0, RESP_SLVERR);
    module_stop_control <= 1'b0;
    acc(1'b0, 12'h7f0, 32'h0, RESP_SLVERR);
    $display("register test done");
  endtask

  task automatic t_dual;
    slow <= 2'h1;
    acc(1'b1, OFF_SRC_PTR, 32'h100, RESP_OKAY);
    acc(1'b1, OFF_DST_PTR, 32'h200, RESP_OKAY);
    acc(1'b1, OFF_CONTROL, 32'h4e4d, RESP_OKAY);
    cyc(1'b0, 32'h100, SZ_WORD);
    cyc(1'b1, 32'h200, SZ_BYTE);
    repeat (4) @(posedge mclk);
    chk(40'(irq_priority_level), 40'h5);
    acc(1'b0, OFF_STATUS, 32'hc0, RESP_OKAY);
    acc(1'b0, OFF_CONTROL, 32'h4e4c, RESP_OKAY);
    acc(1'b0, OFF_SRC_PTR, 32'h102, RESP_OKAY);
    acc(1'b0, OFF_DST_PTR, 32'h201, RESP_OKAY);
    acc(1'b1, OFF_CONTROL, 32'h4e4d, RESP_OKAY);
    acc(1'b0, OFF_CONTROL, 32'h4e4c, RESP_OKAY);
    acc(1'b1, OFF_STATUS, 32'h7c, RESP_OKAY);
    acc(1'b0, OFF_STATUS, 32'h0, RESP_OKAY);
    chk(40'(irq_request), 40'h0);
    $display("dual transfer test done");
  endtask

  task automatic t_ext;
    err <= 1'b1;
    acc(1'b1, OFF_CONTROL, 32'h2163, RESP_OKAY);
    repeat (8) @(posedge mclk);
    chk(40'(cycle_out.valid), 40'h0);
    transfer_request_in <= 1'b1;
    cyc(1'b1, 32'h201, SZ_BYTE);
    chk(40'(transfer_acknowledge_out), 40'h1);
    repeat (4) @(posedge mclk);
    chk(40'(irq_request), 40'h1);
    acc(1'b0, OFF_STATUS, 32'h90, RESP_OKAY);
    err <= 1'b0;
    acc(1'b1, OFF_STATUS, 32'h7c, RESP_OKAY);
    acc(1'b1, OFF_CONTROL, 32'h2153, RESP_OKAY);
    repeat (8) @(posedge mclk);
    chk(40'(cycle_out.valid), 40'h0);
    transfer_request_in <= 1'b0;
    $display("external request test done");
  endtask

  // dual external steal, option set; breakpoint seen mid-transfer
  task automatic t_steal;
    acc(1'b1, OFF_CONTROL, 32'h9171, RESP_OKAY);
    {transfer_request_in, breakpoint_in} <= 2'h3;
    cyc(1'b0, 32'h102, SZ_BYTE);
    chk(40'(transfer_acknowledge_out), 40'h1);
    cyc(1'b1, 32'h201, SZ_BYTE);
    chk(40'(transfer_acknowledge_out), 40'h0);
    {transfer_request_in, breakpoint_in} <= 2'h0;
    repeat (4) @(posedge mclk);
    chk(40'(irq_request), 40'h1);
    acc(1'b0, OFF_STATUS, 32'hc4, RESP_OKAY);
    $display("steal and breakpoint test done");
  endtask

  task automatic summarize;
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // main sequence; t_ext and t_steal use the pointers left by t_dual
  initial begin
    {rstn, supervisor, module_stop_control, err} = 4'b0100;
    {transfer_request_in, last_operand, breakpoint_in} = 3'b010;
    {slow, avs_req, error_cnt, samples_checked} = '0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_dual();
    t_ext();
    t_steal();
    summarize();
  end

  // the whole run needs well under 800 clocks
  initial begin
    #20us;
    error_cnt++;
    summarize();
  end
endmodule
